//--- hw/can_mbx_defines.svh
// Register offsets, field positions and reset values of the mailbox engine
`ifndef CAN_MBX_DEFINES_SVH
`define CAN_MBX_DEFINES_SVH
`define MBX_NUM          16
`define MBX_WORDS        8
`define MBX_AW           7
// Register byte offsets
`define OFS_TX_PENDING   12'h000
`define OFS_TX_CANCEL    12'h004
`define OFS_TX_DONE_ACK  12'h008
`define OFS_ABORT_ACK    12'h00c
`define OFS_RX_COMPLETE  12'h010
`define OFS_REMOTE_REQ   12'h014
`define OFS_UNREAD_OVR   12'h018
`define OFS_MBX_IRQ_MASK 12'h01c
`define OFS_IRQ_FLAG     12'h020
`define OFS_GLB_IRQ_MASK 12'h024
`define OFS_ACC_MASK     12'h028
`define OFS_MBX_DIR      12'h02c
`define OFS_MBX_BASE     12'h400
`define OFS_MBX_TOP      12'h5fc
// Mailbox word layout: word 0 arbitration, 1 control, 2..3 data
`define W_ARB            3'h0
`define W_CTRL           3'h1
`define W_DATA_LO        3'h2
`define W_DATA_HI        3'h3
`define ARB_IDE          31
`define ARB_RTR          30
`define CTRL_DLC_HI      3
`define DLC_MAX          4'h8
// Interrupt flag bit positions and register reset values
`define IRQ_RX           1
`define IRQ_REMOTE       2
`define IRQ_EMPTY        8
`define IRQ_OVR          9
`define IRQ_MASK_RST     16'hffff
`define MBX_MASK_RST     16'hffff
`define MBX_DIR_RST      16'h0001
`endif

//--- hw/can_mbx_pkg.sv
// Types shared by the mailbox engine files
package can_mbx_pkg;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_RD    = 3'b001,
        S_SEND  = 3'b010,
        S_RXCMP = 3'b011,
        S_RXWR  = 3'b100
    } eng_t;
endpackage : can_mbx_pkg

//--- hw/mbx_ram.sv
// Mailbox message store: 16 mailboxes of 8 words, registered read
`timescale 1ns/1ps
`include "can_mbx_defines.svh"
module mbx_ram (
    // Clock
    input  wire logic               clk,
    // Port A: register bus
    input  wire logic               aWe,
    input  wire logic [`MBX_AW-1:0] aAddr,
    input  wire logic [31:0]        aWdata,
    output logic      [31:0]        aRdata,
    // Port B: engine
    input  wire logic               bWe,
    input  wire logic [`MBX_AW-1:0] bAddr,
    input  wire logic [31:0]        bWdata,
    output logic      [31:0]        bRdata
);
    logic [31:0] mem [0:(`MBX_NUM*`MBX_WORDS)-1];

    // No reset: mailbox contents are undefined after power-up
    always_ff @(posedge clk) begin
        if (bWe) begin
            mem[bAddr] <= bWdata;
        end else if (aWe) begin
            mem[aAddr] <= aWdata;
        end
        aRdata <= mem[aAddr];
        bRdata <= mem[bAddr];
    end
endmodule : mbx_ram

//--- hw/can_mailbox_engine.sv
// Mailbox transmit/receive engine with APB register access
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "can_mbx_defines.svh"
module can_mailbox_engine
    import can_mbx_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Transmit side toward bit engine
    output logic             txReq,
    output logic      [31:0] txArb,
    output logic      [3:0]  txDlc,
    output logic      [63:0] txData,
    input  wire logic        txBusy,
    input  wire logic        txDone,
    input  wire logic        txFail,
    // Receive side from bit engine
    input  wire logic        rxValid,
    input  wire logic        rxCrcOk,
    input  wire logic [31:0] rxArb,
    input  wire logic [3:0]  rxDlc,
    input  wire logic [63:0] rxData,
    output logic             rxAck,
    // Interrupt outputs
    output logic             irqRxMbx0,
    output logic             irqRxOther,
    output logic             irqOther
);
    import can_mbx_pkg::*;

    typedef struct packed {
        eng_t        st;
        logic [3:0]  mbx;
        logic [2:0]  word;
        logic        rdWait;
        logic [15:0] txPending;
        logic [15:0] txCancelReq;
        logic [15:0] txDoneAck;
        logic [15:0] abortAck;
        logic [15:0] rxComplete;
        logic [15:0] remoteReq;
        logic [15:0] unreadOvr;
        logic [15:0] mbxIrqMask;
        logic [15:0] irqFlag;
        logic [15:0] glbIrqMask;
        logic [28:0] accMask;
        logic [15:0] mbxDir;
        logic [31:0] arbBuf;
        logic [3:0]  dlcBuf;
        logic [63:0] dataBuf;
        logic        rxRtr;
        logic        mbx0Hit;
        logic        stored;
        logic [15:0] rxHits;
        logic        txReq;
        logic        rxAck;
        logic [31:0] prdata;
        logic        apbRd;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic [31:0] aRdata;
    logic [31:0] bRdata;
    logic        aWe;
    logic        bWe;
    logic [`MBX_AW-1:0] bAddr;
    logic [31:0] bWdata;
    logic        isMbx;
    logic        apbWr;
    logic        apbRdEn;
    logic [15:0] txEligible;
    logic [3:0]  txPick;
    logic        txAny;
    logic [28:0] idMask;
    logic        idHit;
    logic [15:0] wrOne;
    logic [3:0]  payloadBytes;

    assign isMbx   = (paddr >= `OFS_MBX_BASE) && (paddr <= `OFS_MBX_TOP);
    assign apbWr   = psel && penable && pwrite;
    assign apbRdEn = psel && !penable && !pwrite;
    assign aWe     = apbWr && isMbx;
    assign wrOne   = pwdata[15:0];

    // Lowest-numbered mailbox first; mailbox 0 excluded
    assign txEligible = s_r.txPending & ~s_r.mbxDir & 16'hfffe;
    always_comb begin
        txPick = 4'h0;
        txAny  = 1'b0;
        for (int i = `MBX_NUM - 1; i >= 1; i--) begin
            if (txEligible[i]) begin
                txPick = 4'(i);
                txAny  = 1'b1;
            end
        end
    end

    // Compare held arbitration word with incoming identifier
    assign idMask = (s_r.mbx == 4'h0) ? ~s_r.accMask : {29{1'b1}};
    assign idHit  = (bRdata[`ARB_IDE] == s_r.arbBuf[`ARB_IDE])
                 && (((bRdata[28:0] ^ s_r.arbBuf[28:0]) & idMask) == 29'h0)
                 && s_r.mbxDir[s_r.mbx];
    assign payloadBytes = (s_r.dlcBuf > `DLC_MAX) ? `DLC_MAX : s_r.dlcBuf;

    mbx_ram u_ram (
        .clk    (clk),
        .aWe    (aWe),
        .aAddr  (paddr[8:2]),
        .aWdata (pwdata),
        .aRdata (aRdata),
        .bWe    (bWe),
        .bAddr  (bAddr),
        .bWdata (bWdata),
        .bRdata (bRdata)
    );

    always_comb begin
        s_nxt  = s_r;
        bWe    = 1'b0;
        bAddr  = {s_r.mbx, s_r.word};
        bWdata = 32'h0;
        s_nxt.rxAck = rxValid && rxCrcOk;
        s_nxt.apbRd = apbRdEn && isMbx;

        // Software-side clears and writes, before hardware sets
        if (apbWr && !isMbx) begin
            case (paddr)
                `OFS_TX_PENDING:   s_nxt.txPending =
                    s_r.txPending | (wrOne & 16'hfffe);
                `OFS_TX_CANCEL:    s_nxt.txCancelReq =
                    s_r.txCancelReq | (wrOne & s_r.txPending);
                `OFS_TX_DONE_ACK:  s_nxt.txDoneAck  = s_r.txDoneAck & ~wrOne;
                `OFS_ABORT_ACK:    s_nxt.abortAck   = s_r.abortAck & ~wrOne;
                `OFS_RX_COMPLETE:  s_nxt.rxComplete = s_r.rxComplete & ~wrOne;
                `OFS_REMOTE_REQ:   s_nxt.remoteReq  = s_r.remoteReq & ~wrOne;
                `OFS_UNREAD_OVR:   s_nxt.unreadOvr  = s_r.unreadOvr & ~wrOne;
                `OFS_IRQ_FLAG:     s_nxt.irqFlag    =
                    s_r.irqFlag & ~wrOne;
                `OFS_MBX_IRQ_MASK: s_nxt.mbxIrqMask = wrOne;
                `OFS_GLB_IRQ_MASK: s_nxt.glbIrqMask = wrOne;
                `OFS_ACC_MASK:     s_nxt.accMask    = pwdata[28:0];
                `OFS_MBX_DIR:      s_nxt.mbxDir     = wrOne | 16'h0001;
                default: ;
            endcase
        end

        // Cancels take effect at once only while the engine is in S_IDLE
        if (s_r.st == S_IDLE) begin
            for (int i = 1; i < `MBX_NUM; i++) begin
                if (s_nxt.txCancelReq[i]) begin
                    s_nxt.txPending[i]   = 1'b0;
                    s_nxt.txCancelReq[i] = 1'b0;
                    s_nxt.abortAck[i]    = 1'b1;
                    if (!s_r.mbxIrqMask[i]) begin
                        s_nxt.irqFlag[`IRQ_EMPTY] = 1'b1;
                    end
                end
            end
        end

        case (s_r.st)
            S_IDLE: begin
                s_nxt.word = `W_ARB;
                if (rxValid && rxCrcOk) begin
                    s_nxt.arbBuf  = rxArb;
                    s_nxt.dlcBuf  = rxDlc;
                    s_nxt.dataBuf = rxData;
                    s_nxt.rxRtr   = rxArb[`ARB_RTR];
                    s_nxt.mbx     = 4'h0;
                    s_nxt.mbx0Hit = 1'b0;
                    s_nxt.stored  = 1'b0;
                    s_nxt.rxHits  = 16'h0;
                    s_nxt.rdWait  = 1'b1;
                    s_nxt.st      = S_RXCMP;
                end else if (txAny && s_nxt.txPending[txPick]
                             && !txBusy && !s_r.apbRd) begin
                    // Picked only between frames, when the bus is free
                    s_nxt.mbx    = txPick;
                    s_nxt.rdWait = 1'b1;
                    s_nxt.st     = S_RD;
                end
            end
            S_RD: begin
                // Word read latency one cycle, then capture
                if (s_r.rdWait) begin
                    s_nxt.rdWait = 1'b0;
                end else begin
                    case (s_r.word)
                        `W_ARB:     s_nxt.arbBuf = bRdata;
                        `W_CTRL:    s_nxt.dlcBuf =
                            bRdata[`CTRL_DLC_HI:0];
                        `W_DATA_LO: s_nxt.dataBuf[31:0]  = bRdata;
                        default:    s_nxt.dataBuf[63:32] = bRdata;
                    endcase
                    s_nxt.rdWait = 1'b1;
                    if (s_r.word == `W_DATA_HI) begin
                        s_nxt.txReq = 1'b1;
                        s_nxt.st    = S_SEND;
                    end else begin
                        s_nxt.word = s_r.word + 3'h1;
                    end
                end
            end
            S_SEND: begin
                // Cancel requests wait here until the frame ends
                if (txDone) begin
                    s_nxt.txReq = 1'b0;
                    s_nxt.txPending[s_r.mbx]   = 1'b0;
                    s_nxt.txCancelReq[s_r.mbx] = 1'b0;
                    s_nxt.txDoneAck[s_r.mbx]   = 1'b1;
                    if (!s_r.mbxIrqMask[s_r.mbx]) begin
                        s_nxt.irqFlag[`IRQ_EMPTY] = 1'b1;
                    end
                    s_nxt.st = S_IDLE;
                end else if (txFail) begin
                    // Pending stays set so the mailbox competes again
                    s_nxt.txReq = 1'b0;
                    s_nxt.st    = S_IDLE;
                end
            end
            S_RXCMP: begin
                if (s_r.rdWait) begin
                    s_nxt.rdWait = 1'b0;
                end else if (idHit && !(s_r.mbx != 4'h0 && s_r.stored)) begin
                    s_nxt.word = `W_CTRL;
                    s_nxt.st   = S_RXWR;
                end else if (s_r.mbx == 4'hf) begin
                    s_nxt.st = S_IDLE;
                end else begin
                    s_nxt.mbx    = s_r.mbx + 4'h1;
                    s_nxt.rdWait = 1'b1;
                end
            end
            S_RXWR: begin
                bWe = 1'b1;
                case (s_r.word)
                    `W_CTRL:    bWdata = {28'h0, s_r.dlcBuf};
                    `W_DATA_LO: bWdata = s_r.dataBuf[31:0];
                    default:    bWdata = s_r.dataBuf[63:32];
                endcase
                if (s_r.word == `W_DATA_HI) begin
                    if (s_r.rxComplete[s_r.mbx]) begin
                        s_nxt.unreadOvr[s_r.mbx] = 1'b1;
                        s_nxt.irqFlag[`IRQ_OVR]  = 1'b1;
                    end
                    s_nxt.rxComplete[s_r.mbx] = 1'b1;
                    s_nxt.rxHits[s_r.mbx]     = 1'b1;
                    if (s_r.rxRtr) begin
                        s_nxt.remoteReq[s_r.mbx] = 1'b1;
                    end
                    if (!s_r.mbxIrqMask[s_r.mbx]) begin
                        s_nxt.irqFlag[`IRQ_RX] = 1'b1;
                        if (s_r.rxRtr) begin
                            s_nxt.irqFlag[`IRQ_REMOTE] = 1'b1;
                        end
                    end
                    if (s_r.mbx == 4'h0) begin
                        // Masked hit at mailbox 0 keeps searching
                        s_nxt.mbx0Hit = 1'b1;
                        s_nxt.mbx     = 4'h1;
                        s_nxt.rdWait  = 1'b1;
                        s_nxt.word    = `W_ARB;
                        s_nxt.st      = S_RXCMP;
                    end else begin
                        s_nxt.stored = 1'b1;
                        s_nxt.st     = S_IDLE;
                    end
                end else begin
                    s_nxt.word = s_r.word + 3'h1;
                end
            end
            default: s_nxt.st = S_IDLE;
        endcase

        // APB read data
        case (paddr)
            `OFS_TX_PENDING:   s_nxt.prdata = {16'h0, s_r.txPending};
            `OFS_TX_CANCEL:    s_nxt.prdata = {16'h0, s_r.txCancelReq};
            `OFS_TX_DONE_ACK:  s_nxt.prdata = {16'h0, s_r.txDoneAck};
            `OFS_ABORT_ACK:    s_nxt.prdata = {16'h0, s_r.abortAck};
            `OFS_RX_COMPLETE:  s_nxt.prdata = {16'h0, s_r.rxComplete};
            `OFS_REMOTE_REQ:   s_nxt.prdata = {16'h0, s_r.remoteReq};
            `OFS_UNREAD_OVR:   s_nxt.prdata = {16'h0, s_r.unreadOvr};
            `OFS_MBX_IRQ_MASK: s_nxt.prdata = {16'h0, s_r.mbxIrqMask};
            `OFS_IRQ_FLAG:     s_nxt.prdata = {16'h0, s_r.irqFlag};
            `OFS_GLB_IRQ_MASK: s_nxt.prdata = {16'h0, s_r.glbIrqMask};
            `OFS_ACC_MASK:     s_nxt.prdata = {3'h0, s_r.accMask};
            `OFS_MBX_DIR:      s_nxt.prdata = {16'h0, s_r.mbxDir};
            default:           s_nxt.prdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r            <= '0;
            s_r.st         <= S_IDLE;
            s_r.mbxIrqMask <= `MBX_MASK_RST;
            s_r.glbIrqMask <= `IRQ_MASK_RST;
            s_r.mbxDir     <= `MBX_DIR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Mailbox reads see the RAM port once the setup cycle has addressed it
    assign prdata  = isMbx ? aRdata : s_r.prdata;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Bytes past the length code are forced to zero on the way out
    always_comb begin
        for (int b = 0; b < `MBX_WORDS; b++) begin
            txData[b*8 +: 8] = (4'(b) < payloadBytes)
                             ? s_r.dataBuf[b*8 +: 8] : 8'h00;
        end
    end
    assign txReq  = s_r.txReq;
    assign txArb  = s_r.arbBuf;
    assign txDlc  = s_r.dlcBuf;
    assign rxAck  = s_r.rxAck;

    // Global mask bit 1 blocks that flag from the interrupt outputs; the flag itself still sets
    assign irqRxMbx0  = s_r.irqFlag[`IRQ_RX] & s_r.rxComplete[0]
                      & ~s_r.glbIrqMask[`IRQ_RX];
    assign irqRxOther = s_r.irqFlag[`IRQ_RX] & |s_r.rxComplete[15:1]
                      & ~s_r.glbIrqMask[`IRQ_RX];
    assign irqOther   = |(s_r.irqFlag & ~s_r.glbIrqMask
                      & ~(16'h1 << `IRQ_RX));
endmodule : can_mailbox_engine

//--- tb/can_bus_model.sv
// Far-side bit engine model: sends frames, may lose one, injects frames
`timescale 1ns/1ps
module can_bus_model (
    // Clock
    input  wire logic        clk,
    // Scenario controls
    input  wire logic        holdBusy,
    input  wire logic        failFirst,
    // Transmit side
    input  wire logic        txReq,
    output logic             txBusy,
    output logic             txDone,
    output logic             txFail,
    // Receive side
    output logic             rxValid,
    output logic             rxCrcOk,
    output logic [31:0]      rxArb,
    output logic [3:0]       rxDlc,
    output logic [63:0]      rxData
);
    logic       sending = 1'b0;
    logic       failed  = 1'b0;
    logic       lose;
    logic [4:0] cnt     = 5'h0;
    logic [1:0] gap     = 2'h0;
    initial begin
        txDone  = 1'b0;
        txFail  = 1'b0;
        rxValid = 1'b0;
        rxCrcOk = 1'b0;
        rxArb   = 32'h0;
        rxDlc   = 4'h0;
        rxData  = 64'h0;
    end
    assign txBusy = sending | holdBusy;
    assign lose   = failFirst & ~failed;
    // Gap lets a finished request drop before it is seen again
    always @(posedge clk) begin
        txDone <= 1'b0;
        txFail <= 1'b0;
        if (gap != 2'h0) begin
            gap <= gap - 2'h1;
        end else if (sending) begin
            cnt <= cnt + 5'h1;
            if (cnt == 5'h14) begin
                sending <= 1'b0;
                gap     <= 2'h3;
                failed  <= lose;
                txFail  <= lose;
                txDone  <= ~lose;
            end
        end else if (txReq) begin
            sending <= 1'b1;
            cnt     <= 5'h0;
        end
    end
    // Released lines other than rxDlc show the inverse, not the last value
    task automatic frame(input logic [31:0] a, input logic [63:0] p,
                         input logic ok);
        rxValid <= 1'b1;
        rxCrcOk <= ok;
        rxArb   <= a;
        rxDlc   <= 4'h8;
        rxData  <= p;
        @(posedge clk);
        rxValid <= 1'b0;
        rxCrcOk <= ~ok;
        rxArb   <= ~a;
        rxData  <= ~p;
        @(posedge clk);
    endtask : frame
endmodule : can_bus_model

//--- tb/can_mailbox_engine_assertions.sv
// Port checks for the mailbox engine
`timescale 1ns/1ps
module can_mailbox_engine_assertions (
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Bit engine side
    input wire logic        txReq,
    input wire logic [31:0] txArb,
    input wire logic [3:0]  txDlc,
    input wire logic [63:0] txData,
    input wire logic        txBusy,
    input wire logic        txDone,
    input wire logic        txFail,
    input wire logic        rxValid,
    input wire logic        rxCrcOk,
    input wire logic        rxAck
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence goodFrame;
        rxValid && rxCrcOk;
    endsequence
    sequence holding;
        txReq && !txDone && !txFail;
    endsequence
    a_ack_good: assert property (goodFrame |=> rxAck)
        else $error("good frame not acknowledged");
    a_ack_cause: assert property (rxAck |-> $past(rxValid && rxCrcOk))
        else $error("acknowledge without good frame");
    a_ack_single: assert property (rxAck |=> !rxAck)
        else $error("acknowledge longer than one cycle");
    a_req_hold: assert property (holding |=> txReq)
        else $error("request dropped before answer");
    a_frame_stable: assert property (holding |=> $stable(txArb)
        && $stable(txDlc) && $stable(txData))
        else $error("frame changed while requested");
    a_pick_idle: assert property ($rose(txReq) |-> !txBusy)
        else $error("request raised during bus frame");
    a_pad_zero: assert property (txReq && txDlc < 4'h8
        |-> (txData >> {txDlc, 3'b000}) == 64'h0)
        else $error("bytes beyond length not zero");
    a_req_drop: assert property (txDone |-> ##[1:2] !txReq)
        else $error("request kept after completion");
endmodule : can_mailbox_engine_assertions
bind can_mailbox_engine can_mailbox_engine_assertions chk (
    .clk(clk), .arst_n(arst_n), .txReq(txReq), .txArb(txArb),
    .txDlc(txDlc), .txData(txData), .txBusy(txBusy), .txDone(txDone),
    .txFail(txFail), .rxValid(rxValid), .rxCrcOk(rxCrcOk), .rxAck(rxAck)
);

//--- tb/can_mailbox_engine_bench.sv
// Self-checking bench for the mailbox engine
`timescale 1ns/1ps
`include "can_mbx_defines.svh"
module can_mailbox_engine_bench;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic        txReq, txBusy, txDone, txFail, rxValid, rxCrcOk, rxAck;
    logic        irqRxMbx0, irqRxOther, irqOther, holdBusy, failFirst;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, txArb, rxArb, rd;
    logic [3:0]  txDlc, rxDlc;
    logic [63:0] txData, rxData;
    int          miscompares, n_compared;
    localparam logic [31:0] IDA = 32'h0aa40000;
    localparam logic [63:0] PAY = 64'h8877665544332211;

    can_mailbox_engine uut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txReq(txReq), .txArb(txArb),
        .txDlc(txDlc), .txData(txData), .txBusy(txBusy), .txDone(txDone),
        .txFail(txFail), .rxValid(rxValid), .rxCrcOk(rxCrcOk),
        .rxArb(rxArb), .rxDlc(rxDlc), .rxData(rxData), .rxAck(rxAck),
        .irqRxMbx0(irqRxMbx0), .irqRxOther(irqRxOther), .irqOther(irqOther)
    );
    can_bus_model bm (
        .clk(clk), .holdBusy(holdBusy), .failFirst(failFirst),
        .txReq(txReq), .txBusy(txBusy), .txDone(txDone), .txFail(txFail),
        .rxValid(rxValid), .rxCrcOk(rxCrcOk), .rxArb(rxArb),
        .rxDlc(rxDlc), .rxData(rxData)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Entered just after an edge; idles one cycle so psel is low for one cycle between transfers
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic w = 1'b1);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({62'h0, pready, pslverr}, 64'h2);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        wr(a, 32'h0, 1'b0);
        chk({32'h0, rd}, {32'h0, e});
    endtask : rdc

    function automatic logic [11:0] ma(input int m, input int w);
        return 12'h400 + 12'(m * 32 + w * 4);
    endfunction : ma

    // Search plus store finish well inside this span
    task automatic rx(input logic [31:0] a, input logic [63:0] p,
                      input logic ok);
        bm.frame(a, p, ok);
        repeat (60) @(posedge clk);
    endtask : rx

    task automatic waitTx(input logic done);
        int n;
        n = 0;
        while ((done ? txDone : txReq) !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk({63'h0, done ? txDone : txReq}, 64'h1);
    endtask : waitTx

    initial begin
        arst_n      = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h0;
        pwdata      = 32'h0;
        holdBusy    = 1'b0;
        failFirst   = 1'b1;
        miscompares = 0;
        n_compared  = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rdc(`OFS_MBX_IRQ_MASK, 32'h0000ffff);
        rdc(`OFS_GLB_IRQ_MASK, 32'h0000ffff);
        rdc(`OFS_MBX_DIR, 32'h00000001);
        rdc(12'h100, 32'h0);
        $display("reset test done");
        wr(`OFS_GLB_IRQ_MASK, 32'h0);
        wr(`OFS_MBX_IRQ_MASK, 32'h0000ffe4);
        wr(ma(1, 0), 32'h048c0000);
        wr(ma(1, 1), 32'h3);
        wr(ma(1, 2), PAY[31:0]);
        wr(ma(1, 3), PAY[63:32]);
        wr(`OFS_TX_PENDING, 32'h2);
        waitTx(1'b0);
        chk({32'h0, txArb}, 64'h048c0000);
        chk({60'h0, txDlc}, 64'h3);
        chk(txData, 64'h332211);
        waitTx(1'b1);
        rdc(`OFS_TX_PENDING, 32'h0);
        rdc(`OFS_TX_DONE_ACK, 32'h2);
        rdc(`OFS_IRQ_FLAG, 32'h100);
        chk({63'h0, irqOther}, 64'h1);
        wr(`OFS_TX_DONE_ACK, 32'h2);
        wr(`OFS_IRQ_FLAG, 32'h100);
        rdc(`OFS_TX_DONE_ACK, 32'h0);
        chk({63'h0, irqOther}, 64'h0);
        failFirst <= 1'b0;
        wr(ma(3, 0), 32'h9abcdef1);
        wr(ma(3, 1), 32'h8);
        wr(ma(3, 2), PAY[31:0]);
        wr(ma(3, 3), PAY[63:32]);
        wr(`OFS_TX_PENDING, 32'h8);
        waitTx(1'b0);
        chk({32'h0, txArb}, 64'h9abcdef1);
        chk(txData, PAY);
        bm.frame(IDA, PAY, 1'b1);
        wr(`OFS_TX_CANCEL, 32'h8);
        waitTx(1'b1);
        rdc(`OFS_ABORT_ACK, 32'h0);
        rdc(`OFS_TX_DONE_ACK, 32'h8);
        wr(`OFS_IRQ_FLAG, 32'h100);
        wr(`OFS_TX_PENDING, 32'h1);
        rdc(`OFS_TX_PENDING, 32'h0);
        $display("transmit test done");
        holdBusy <= 1'b1;
        wr(`OFS_TX_PENDING, 32'h4);
        wr(`OFS_TX_PENDING, 32'h0);
        rdc(`OFS_TX_PENDING, 32'h4);
        wr(`OFS_TX_CANCEL, 32'h4);
        rdc(`OFS_TX_PENDING, 32'h0);
        rdc(`OFS_ABORT_ACK, 32'h4);
        rdc(`OFS_IRQ_FLAG, 32'h0);
        holdBusy <= 1'b0;
        $display("cancel test done");
        wr(`OFS_MBX_DIR, 32'h31);
        wr(`OFS_ACC_MASK, 32'h000c0000);
        wr(ma(0, 0), 32'h0aa80000);
        wr(ma(4, 0), IDA);
        wr(ma(5, 0), IDA);
        rx(IDA, PAY, 1'b1);
        rdc(`OFS_RX_COMPLETE, 32'h11);
        rdc(ma(4, 2), PAY[31:0]);
        rdc(`OFS_IRQ_FLAG, 32'h2);
        chk({62'h0, irqRxMbx0, irqRxOther}, 64'h3);
        rx(IDA, ~PAY, 1'b0);
        rdc(ma(4, 2), PAY[31:0]);
        rx(IDA, ~PAY, 1'b1);
        rdc(ma(4, 3), ~PAY[63:32]);
        rdc(`OFS_UNREAD_OVR, 32'h11);
        rdc(`OFS_IRQ_FLAG, 32'h202);
        rx(IDA | 32'h40000000, PAY, 1'b1);
        rdc(`OFS_REMOTE_REQ, 32'h11);
        wr(`OFS_RX_COMPLETE, 32'h11);
        rx(32'h0a800000, PAY, 1'b1);
        rdc(`OFS_RX_COMPLETE, 32'h0);
        $display("receive test done");
        end_sim;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim;
    end
endmodule : can_mailbox_engine_bench
